// File: design/idr_pkg.sv
// Contract
// - accel self-test failure sets bit 10
// - gyro 2 self-test failure sets bit 9
// - gyro 1 self-test failure sets bit 8
// - any sensor self-test failure sets bit 5
// - sync lock loss in scaled mode sets 7
// - flash test CRC mismatch sets bit 6
// - low supply sets bit 4, halts data
// - supply good 250 ms, reinit and resume
// - frame not multiple of 16 sets 3
// - failed flash update sets bit 2
// - data path overrun sets bit 1
// - status read returns flags, then clears
// - flags stay set until read clears
// - persisting condition sets flag again
// - rate is 32-bit high/low two's complement
// - high word LSB weight set by model
package idr_pkg;
  // register addresses (7-bit field of a command word)
  localparam logic [6:0] DIAG_ADDR  = 7'h02;
  localparam logic [6:0] XLO_ADDR   = 7'h04;
  localparam logic [6:0] XHI_ADDR   = 7'h06;
  localparam logic [6:0] YLO_ADDR   = 7'h08;
  localparam logic [6:0] YHI_ADDR   = 7'h0A;
  localparam logic [6:0] ZLO_ADDR   = 7'h0C;
  localparam logic [6:0] ZHI_ADDR   = 7'h0E;
  localparam logic [6:0] RANGE_ADDR = 7'h5E;
  localparam logic [6:0] MISC_ADDR  = 7'h60;
  localparam logic [6:0] CMD_ADDR   = 7'h68;
  // status bit positions
  localparam int B_ACCL = 10;
  localparam int B_GYR2 = 9;
  localparam int B_GYR1 = 8;
  localparam int B_SCLK = 7;
  localparam int B_MEM  = 6;
  localparam int B_SENS = 5;
  localparam int B_STBY = 4;
  localparam int B_LINK = 3;
  localparam int B_FLUP = 2;
  localparam int B_OVR  = 1;
  localparam logic [15:0] DIAG_RESET = 16'h0000;
  localparam logic [15:0] DIAG_USED  = 16'h07FE;
  // command word bits
  localparam int C_SELF_TEST = 2;
  localparam int C_FLASH_UPD = 3;
  localparam int C_FLASH_TST = 4;
  localparam int C_SW_RESET  = 7;
  // misc control: sync mode field and its scaled code
  localparam int          MISC_SYNC_LSB = 2;
  localparam logic [1:0]  SYNC_SCALED   = 2'h2;
  localparam logic [7:0]  MISC_RESET    = 8'hC1;
  // link word length
  localparam logic [3:0]  WORD_LAST = 4'hF;
  // range codes: 0.00625, 0.025, 0.1 deg/s per high-word LSB
  localparam logic [15:0] RANGE_125  = 16'h0001;
  localparam logic [15:0] RANGE_500  = 16'h0002;
  localparam logic [15:0] RANGE_2000 = 16'h0003;
  // recovery time after supply returns
  localparam int CLK_HZ       = 10000000;
  localparam int RECOVER_MS   = 250;
  localparam int RECOVER_CYC  = RECOVER_MS * (CLK_HZ / 1000);
  // flash check polynomial and seed
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  // supply supervisor states
  typedef enum logic [2:0] {
    PW_RUN     = 3'h1,
    PW_STANDBY = 3'h2,
    PW_RECOVER = 3'h4
  } idr_pwr_t;
endpackage

// File: design/idr_sync.sv
`timescale 1ns/100ps
`default_nettype none
// three-stage synchroniser; a change is taken once stages two and three agree
module idr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // foreign level in, settled level out
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] s1; // metastability catcher, read by s2 only
  logic [W-1:0] s2; // second stage
  logic [W-1:0] s3; // third stage

  // shift chain
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // accept only an agreed value, filters one-cycle skew on buses
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '0;
    end else if (s2 == s3) begin
      q <= s3;
    end
  end
endmodule
`default_nettype wire

// File: design/idr_crc16.sv
`timescale 1ns/100ps
`default_nettype none
// word-serial crc over flash contents, one 16-bit word per cycle
module idr_crc16
  import idr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // control and data
  input  wire logic        clear,
  input  wire logic        valid,
  input  wire logic [15:0] data,
  // running remainder
  output var  logic [15:0] crc
);
  // one word through the polynomial, msb first
  function automatic logic [15:0] step(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ w[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // accumulator; clear wins so a fresh test never sees stale state
  always_ff @(posedge clk) begin
    if (!nrst || clear) begin
      crc <= CRC_SEED;
    end else if (valid) begin
      crc <= step(crc, data);
    end
  end
endmodule
`default_nettype wire

// File: design/idr_diag_spi.sv
`timescale 1ns/100ps
`default_nettype none
// diagnostic status word and rate readout behind a mode-3 serial link
module idr_diag_spi
  import idr_pkg::*;
#(
  parameter int RECOVER_CYCLES = RECOVER_CYC,
  parameter logic [15:0] RANGE_CODE = RANGE_125
) (
  // system clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // serial link from host
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output var  logic        miso,
  output var  logic        miso_oe,
  // sensor self test
  output var  logic        self_test_start,
  input  wire logic        self_test_done,
  input  wire logic        accel_fail,
  input  wire logic        gyro1_fail,
  input  wire logic        gyro2_fail,
  // sample clock lock to external sync
  input  wire logic        sync_lock_lost,
  // flash test and update
  output var  logic        flash_test_start,
  input  wire logic        flash_rd_valid,
  input  wire logic [15:0] flash_rd_data,
  input  wire logic        flash_rd_last,
  input  wire logic [15:0] flash_crc_stored,
  output var  logic        flash_update_start,
  input  wire logic        flash_update_done,
  input  wire logic        flash_update_ok,
  // supply monitor pin
  input  wire logic        supply_low,
  // data path
  input  wire logic        overrun,
  input  wire logic        rate_valid,
  input  wire logic [31:0] x_rate,
  input  wire logic [31:0] y_rate,
  input  wire logic [31:0] z_rate,
  output var  logic        data_halt,
  output var  logic        reinit,
  output var  logic        sw_reset_req,
  output var  logic [7:0]  misc_control_word
);

  // ---------------- link domain (sclk) ----------------
  logic [3:0]  bit_cnt;   // position in current word, cleared by idle select
  logic [3:0]  edge_cnt;  // free running edge count for length check
  logic [14:0] rx_shift;  // incoming bits
  logic [15:0] rx_word;   // last complete word, stable until next one
  logic        rx_tgl;    // flips once per complete word
  logic [15:0] tx_shift;  // outgoing bits, msb on the pin
  logic [15:0] tx_word;   // answer prepared by system domain

  // word alignment restarts on every select; constant under async clear
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= 4'h0;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // edge counter; only sampled by the system side while sclk stands still
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      edge_cnt <= 4'h0;
    end else begin
      edge_cnt <= edge_cnt + 4'h1;
    end
  end

  // receive: host changes mosi on falling edge, we sample on rising
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      rx_shift <= 15'h0000;
      rx_word  <= 16'h0000;
      rx_tgl   <= 1'b0;
    end else begin
      rx_shift <= {rx_shift[13:0], mosi};
      if (bit_cnt == WORD_LAST) begin
        rx_word <= {rx_shift, mosi};
        rx_tgl  <= ~rx_tgl;
      end
    end
  end

  // transmit: reload on the first falling edge of each word, else shift on falling edge
  // tx_word is only reloaded during the stall between words, so it is
  // quiet whenever this edge can sample it
  always_ff @(negedge sclk or negedge nrst) begin
    if (!nrst) begin
      tx_shift <= 16'h0000;
    end else if (bit_cnt == 4'h0) begin
      tx_shift <= tx_word;
    end else begin
      tx_shift <= {tx_shift[14:0], 1'b0};
    end
  end
  assign miso = tx_shift[15];

  // ---------------- crossings into system domain ----------------
  logic       cs_s;      // settled select level
  logic       tgl_s;     // settled word toggle
  logic [3:0] ecnt_s;    // settled edge count
  logic       cs_d;      // select one cycle ago
  logic       tgl_d;     // toggle one cycle ago
  logic [3:0] ecnt_start; // edge count at frame start

  idr_sync #(.W(1)) u_sync_cs (
    .clk  (clk),
    .nrst (nrst),
    .d    (~cs_n),
    .q    (cs_s)
  );
  idr_sync #(.W(1)) u_sync_tgl (
    .clk  (clk),
    .nrst (nrst),
    .d    (rx_tgl),
    .q    (tgl_s)
  );
  idr_sync #(.W(4)) u_sync_ecnt (
    .clk  (clk),
    .nrst (nrst),
    .d    (edge_cnt),
    .q    (ecnt_s)
  );

  logic word_ev;    // a new word has arrived
  logic frame_beg;  // select went active
  logic frame_end;  // select went idle
  assign word_ev   = tgl_s ^ tgl_d;
  assign frame_beg = cs_s & ~cs_d;
  assign frame_end = ~cs_s & cs_d;

  // edge history and pin drive enable
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cs_d       <= 1'b0;
      tgl_d      <= 1'b0;
      ecnt_start <= 4'h0;
      miso_oe    <= 1'b0;
    end else begin
      cs_d    <= cs_s;
      tgl_d   <= tgl_s;
      miso_oe <= cs_s;  // host must allow select setup for this
      if (frame_beg) begin
        ecnt_start <= ecnt_s;
      end
    end
  end

  // length error: edges in a frame not a whole number of words
  logic frame_err;
  assign frame_err = frame_end && (ecnt_s != ecnt_start);

  // ---------------- command decode ----------------
  logic       is_wr;
  logic [6:0] cmd_addr;
  logic [7:0] cmd_data;
  logic       wr_cmd;    // write to global command word
  logic       rd_diag;   // read of status word
  assign is_wr    = rx_word[15];
  assign cmd_addr = rx_word[14:8];
  assign cmd_data = rx_word[7:0];
  assign wr_cmd   = word_ev && is_wr && (cmd_addr == CMD_ADDR);
  assign rd_diag  = word_ev && !is_wr && (cmd_addr == DIAG_ADDR);

  // misc control byte, written by host, steers the sync check
  always_ff @(posedge clk) begin
    if (!nrst) begin
      misc_control_word <= MISC_RESET;
    end else if (word_ev && is_wr && cmd_addr == MISC_ADDR) begin
      misc_control_word <= cmd_data;
    end
  end

  // command strobes, one cycle each
  always_ff @(posedge clk) begin
    if (!nrst) begin
      self_test_start    <= 1'b0;
      flash_update_start <= 1'b0;
      flash_test_start   <= 1'b0;
      sw_reset_req       <= 1'b0;
    end else begin
      self_test_start    <= wr_cmd && cmd_data[C_SELF_TEST];
      flash_update_start <= wr_cmd && cmd_data[C_FLASH_UPD];
      flash_test_start   <= wr_cmd && cmd_data[C_FLASH_TST];
      sw_reset_req       <= wr_cmd && cmd_data[C_SW_RESET];
    end
  end

  // ---------------- flash test ----------------
  logic [15:0] crc_now;  // running remainder
  logic        crc_chk;  // last word absorbed, compare now
  logic        mem_err;  // remainder differs from stored value

  idr_crc16 u_crc (
    .clk   (clk),
    .nrst  (nrst),
    .clear (flash_test_start),
    .valid (flash_rd_valid),
    .data  (flash_rd_data),
    .crc   (crc_now)
  );

  // compare one cycle after the last word is absorbed
  always_ff @(posedge clk) begin
    if (!nrst) begin
      crc_chk <= 1'b0;
    end else begin
      crc_chk <= flash_rd_valid && flash_rd_last;
    end
  end
  assign mem_err = crc_chk && (crc_now != flash_crc_stored);

  // ---------------- supply supervisor ----------------
  logic        low_s;     // settled supply-low pin
  idr_pwr_t    pwr;       // supervisor state
  idr_pwr_t    next_pwr;  // next state
  logic [21:0] rec_cnt;   // time supply has been good
  logic        rec_done;  // good long enough

  idr_sync #(.W(1)) u_sync_low (
    .clk  (clk),
    .nrst (nrst),
    .d    (supply_low),
    .q    (low_s)
  );

  assign rec_done = (rec_cnt == 22'(RECOVER_CYCLES - 1));

  // state choice; a dip during recovery restarts the wait
  always_comb begin
    next_pwr = pwr;
    unique case (pwr)
      PW_RUN: begin
        if (low_s) next_pwr = PW_STANDBY;
      end
      PW_STANDBY: begin
        if (!low_s) next_pwr = PW_RECOVER;
      end
      PW_RECOVER: begin
        if (low_s) begin
          next_pwr = PW_STANDBY;
        end else if (rec_done) begin
          next_pwr = PW_RUN;
        end
      end
      default: next_pwr = PW_STANDBY; // illegal code: play safe
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwr <= PW_RUN;
    end else begin
      pwr <= next_pwr;
    end
  end

  // recovery timer runs only in recovery
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rec_cnt <= 22'h000000;
    end else if (pwr == PW_RECOVER && !rec_done) begin
      rec_cnt <= rec_cnt + 22'h000001;
    end else if (pwr != PW_RECOVER) begin
      rec_cnt <= 22'h000000;
    end
  end

  // halt level and reinit strobe seen by the data path
  always_ff @(posedge clk) begin
    if (!nrst) begin
      data_halt <= 1'b0;
      reinit    <= 1'b0;
    end else begin
      data_halt <= (next_pwr != PW_RUN);
      reinit    <= (pwr == PW_RECOVER) && (next_pwr == PW_RUN);
    end
  end

  // ---------------- rate capture ----------------
  logic [31:0] x_hold; // held sample, frozen while halted
  logic [31:0] y_hold;
  logic [31:0] z_hold;

  // capture all three axes together so a read pair stays coherent
  always_ff @(posedge clk) begin
    if (!nrst) begin
      x_hold <= 32'h00000000;
      y_hold <= 32'h00000000;
      z_hold <= 32'h00000000;
    end else if (rate_valid && !data_halt) begin
      x_hold <= x_rate;
      y_hold <= y_rate;
      z_hold <= z_rate;
    end
  end

  // ---------------- status flags ----------------
  logic [15:0] diag;       // diagnostic_flags register
  logic [15:0] diag_set;   // conditions raising flags this cycle
  logic [15:0] next_diag;  // next flag value
  logic        any_fail;   // any sensor failed self test

  assign any_fail = accel_fail | gyro1_fail | gyro2_fail;

  // gather the events; levels here keep re-raising their flag
  always_comb begin
    diag_set         = 16'h0000;
    diag_set[B_ACCL] = self_test_done & accel_fail;
    diag_set[B_GYR2] = self_test_done & gyro2_fail;
    diag_set[B_GYR1] = self_test_done & gyro1_fail;
    diag_set[B_SENS] = self_test_done & any_fail;
    diag_set[B_SCLK] = sync_lock_lost &
      (misc_control_word[MISC_SYNC_LSB +: 2] == SYNC_SCALED);
    diag_set[B_MEM]  = mem_err;
    diag_set[B_STBY] = (pwr == PW_STANDBY);
    diag_set[B_LINK] = frame_err;
    diag_set[B_FLUP] = flash_update_done & ~flash_update_ok;
    diag_set[B_OVR]  = overrun;
  end

  // read clears, but a same-cycle event survives the clear
  always_comb begin
    next_diag = rd_diag ? DIAG_RESET : diag;
    next_diag = (next_diag | diag_set) & DIAG_USED;
  end

  // flag register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      diag <= DIAG_RESET;
    end else begin
      diag <= next_diag;
    end
  end

  // ---------------- read answer ----------------
  logic [15:0] rd_val; // value for addressed register

  // unmapped addresses answer zero
  always_comb begin
    rd_val = 16'h0000;
    unique case (cmd_addr)
      DIAG_ADDR:  rd_val = diag & DIAG_USED;
      XLO_ADDR:   rd_val = x_hold[15:0];
      XHI_ADDR:   rd_val = x_hold[31:16];
      YLO_ADDR:   rd_val = y_hold[15:0];
      YHI_ADDR:   rd_val = y_hold[31:16];
      ZLO_ADDR:   rd_val = z_hold[15:0];
      ZHI_ADDR:   rd_val = z_hold[31:16];
      RANGE_ADDR: rd_val = RANGE_CODE;
      MISC_ADDR:  rd_val = {8'h00, misc_control_word};
      default:    rd_val = 16'h0000;
    endcase
  end

  // answer word handed to the link; a write leaves it untouched
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_word <= 16'h0000;
    end else if (word_ev && !is_wr) begin
      tx_word <= rd_val;
    end
  end

endmodule
`default_nettype wire

// File: verif/idr_diag_spi_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// pin-level checks on command pulses, supply supervision and link drive
module idr_diag_spi_monitor #(
  parameter int RECOVER_CYCLES = 20
) (
  // system clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link select and driver enable
  input wire logic cs_n,
  input wire logic miso_oe,
  // command pulses
  input wire logic self_test_start,
  input wire logic flash_test_start,
  input wire logic flash_update_start,
  input wire logic sw_reset_req,
  // supply supervision
  input wire logic supply_low,
  input wire logic data_halt,
  input wire logic reinit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // cycles halted with the supply good; a stuck halt shows as a runaway count
  int unsigned wait_cnt;
  always_ff @(posedge clk) begin
    if (!nrst || supply_low || !data_halt) begin
      wait_cnt <= 0;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
  // steps of the supply and select behaviour
  // three sync stages, the agreement flop and the halt flop take six samples
  sequence s_low_held; supply_low[*6]; endsequence
  sequence s_sel_held; (!cs_n)[*6]; endsequence
  sequence s_idle_held; cs_n[*6]; endsequence
  property p_halt_enter; $rose(supply_low) |-> ##[1:6] data_halt; endproperty
  property p_halt_hold; s_low_held |-> data_halt; endproperty
  property p_recover_max; wait_cnt <= RECOVER_CYCLES + 8; endproperty
  property p_recover_min; $fell(data_halt) |-> $past(wait_cnt) >= RECOVER_CYCLES; endproperty
  property p_st_pulse; self_test_start |=> !self_test_start; endproperty
  property p_ft_pulse; flash_test_start |=> !flash_test_start; endproperty
  property p_fu_pulse; flash_update_start |=> !flash_update_start; endproperty
  property p_sw_pulse; sw_reset_req |=> !sw_reset_req; endproperty
  property p_oe_on; s_sel_held |-> miso_oe; endproperty
  property p_oe_off; s_idle_held |-> !miso_oe; endproperty
  a_halt_enter: assert property (p_halt_enter)
    else $error("halt late after supply drop");
  a_halt_hold: assert property (p_halt_hold)
    else $error("no halt while supply low");
  a_recover_max: assert property (p_recover_max)
    else $error("recovery too long");
  a_recover_min: assert property (p_recover_min)
    else $error("recovery too short");
  a_st_pulse: assert property (p_st_pulse)
    else $error("self test start not one cycle");
  a_ft_pulse: assert property (p_ft_pulse)
    else $error("flash test start not one cycle");
  a_fu_pulse: assert property (p_fu_pulse)
    else $error("update start not one cycle");
  a_sw_pulse: assert property (p_sw_pulse)
    else $error("reset request not one cycle");
  a_oe_on: assert property (p_oe_on)
    else $error("miso not driven while selected");
  a_oe_off: assert property (p_oe_off)
    else $error("miso driven while deselected");
endmodule
`default_nettype wire

// File: verif/idr_host.sv
`timescale 1ns/100ps
`default_nettype none
// host master model, mode 3, 48 ns link clock that stands high between frames
module idr_host (
  // link pins
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // one select frame of nb clocks, msb first; nb not a multiple of 16 breaks framing
  task automatic frame(input logic [15:0] w, input int nb, output logic [15:0] r);
    r = 16'h0000;
    // step off the system clock edge that a caller may have just waited on
    #7;
    cs_n = 1'b0;
    #600;
    for (int i = 0; i < nb; i++) begin
      sclk = 1'b0;
      mosi = w[15-i];
      #24;
      sclk = 1'b1;
      r = {r[14:0], miso};
      #24;
    end
    cs_n = 1'b1;
    // released line: inverse so a stale bit is never mistaken for data
    mosi = ~mosi;
    #1200;
  endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
// self-checking bench for the status word and rate readout
module testbench
  import idr_pkg::*;
();
  localparam int RCY = 20;  // short recovery keeps the run brief
  // design pins
  logic        clk, nrst, sclk, cs_n, mosi, miso, miso_oe;
  logic        self_test_start, self_test_done, accel_fail, gyro1_fail, gyro2_fail;
  logic        sync_lock_lost, flash_test_start, flash_rd_valid, flash_rd_last;
  logic [15:0] flash_rd_data, flash_crc_stored;
  logic        flash_update_start, flash_update_done, flash_update_ok;
  logic        supply_low, overrun, rate_valid, data_halt, reinit, sw_reset_req;
  logic [31:0] x_rate, y_rate, z_rate;
  logic [7:0]  misc_control_word;
  // bookkeeping
  int          fails, check_count, cyc;
  int          pc [5];  // pulse counts
  wire logic [4:0] pv = {reinit, sw_reset_req, flash_update_start, flash_test_start,
                         self_test_start};
  idr_host idr_host_i (.sclk, .cs_n, .mosi, .miso);
  idr_diag_spi #(.RECOVER_CYCLES(RCY), .RANGE_CODE(RANGE_500)) idr_diag_spi_i (
    .clk, .nrst, .sclk, .cs_n, .mosi, .miso, .miso_oe, .self_test_start,
    .self_test_done, .accel_fail, .gyro1_fail, .gyro2_fail, .sync_lock_lost,
    .flash_test_start, .flash_rd_valid, .flash_rd_data, .flash_rd_last, .flash_crc_stored,
    .flash_update_start, .flash_update_done, .flash_update_ok, .supply_low, .overrun,
    .rate_valid, .x_rate, .y_rate, .z_rate, .data_halt, .reinit, .sw_reset_req,
    .misc_control_word);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // count pulses; a hang runs into the cycle ceiling
  always @(posedge clk) begin
    for (int i = 0; i < 5; i++) begin
      if (pv[i] === 1'b1) pc[i]++;
    end
    cyc++;
    if (cyc == 30000) begin
      fails++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    idr_host_i.frame({1'b1, a, d}, 16, r);
  endtask
  // the answer is ready within the gap between frames, so it rides out in the
  // very next word; one dummy read of an empty slot carries it
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    idr_host_i.frame({1'b0, a, 8'h00}, 16, d);
    idr_host_i.frame(16'h0000, 16, d);
  endtask
  task automatic diag(input logic [15:0] e);
    logic [15:0] d;
    rd(DIAG_ADDR, d);
    chk(32'(d), 32'(e));
  endtask
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      c = (c[15] ^ w[i]) ? {c[14:0], 1'b0} ^ CRC_POLY : {c[14:0], 1'b0};
    end
    return c;
  endfunction
  task automatic t_reset();
    logic [15:0] d;
    diag(DIAG_RESET);
    chk(32'(misc_control_word), 32'(MISC_RESET));
    rd(RANGE_ADDR, d);
    chk(32'(d), 32'(RANGE_500));
    rd(7'h7E, d);
    chk(32'(d), 0);
  endtask
  task automatic t_selftest();
    logic [2:0] f;
    for (int k = 0; k < 4; k++) begin
      f = 3'b100 >> k;
      wr(CMD_ADDR, 8'h04);
      chk(pc[0], k + 1);
      @(posedge clk);
      {accel_fail, gyro2_fail, gyro1_fail} <= f;
      self_test_done <= 1'b1;
      @(posedge clk);
      self_test_done <= 1'b0;
      {accel_fail, gyro2_fail, gyro1_fail} <= 3'b000;
      diag({5'h00, f, 2'b00, |f, 5'h00});
    end
  endtask
  task automatic t_sync();
    @(posedge clk);
    sync_lock_lost <= 1'b1;
    diag(16'h0000);
    wr(MISC_ADDR, 8'hC9);
    chk(32'(misc_control_word), 32'hC9);
    diag(16'h0080);
    @(posedge clk);
    sync_lock_lost <= 1'b0;
    diag(16'h0080);
    diag(16'h0000);
  endtask
  task automatic t_flash();
    logic [15:0] c;
    c = crc16(CRC_SEED, 16'hA55A);
    for (int k = 0; k < 2; k++) begin
      wr(CMD_ADDR, 8'h10);
      chk(pc[1], k + 1);
      @(posedge clk);
      {flash_rd_valid, flash_rd_last} <= 2'b11;
      flash_rd_data <= 16'hA55A;
      flash_crc_stored <= c ^ 16'(k);
      @(posedge clk);
      {flash_rd_valid, flash_rd_last} <= 2'b00;
      repeat (3) @(posedge clk);
      diag(k ? 16'h0040 : 16'h0000);
    end
  endtask
  task automatic t_rate();
    logic [15:0] d;
    logic [6:0]  ra [6];
    logic [31:0] rv [3];
    ra = '{XHI_ADDR, XLO_ADDR, YHI_ADDR, YLO_ADDR, ZHI_ADDR, ZLO_ADDR};
    rv = '{32'hB1E00000, 32'h00000002, 32'hFFFFFFFF};
    @(posedge clk);
    {x_rate, y_rate, z_rate} <= {rv[0], rv[1], rv[2]};
    rate_valid <= 1'b1;
    @(posedge clk);
    rate_valid <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], d);
      chk(32'(d), 32'(i[0] ? rv[i/2][15:0] : rv[i/2][31:16]));
    end
  endtask
  task automatic t_supply();
    logic [15:0] d;
    @(posedge clk);
    supply_low <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'(data_halt), 1);
    x_rate <= 32'h00010001;
    rate_valid <= 1'b1;
    @(posedge clk);
    rate_valid <= 1'b0;
    rd(XHI_ADDR, d);
    chk(32'(d), 32'hB1E0);
    diag(16'h0010);
    diag(16'h0010);
    @(posedge clk);
    supply_low <= 1'b0;
    repeat (RCY) @(posedge clk);
    chk(32'(data_halt), 1);
    repeat (12) @(posedge clk);
    chk(32'(data_halt), 0);
    chk(pc[4], 1);
    diag(16'h0010);
    diag(16'h0000);
  endtask
  task automatic t_frame();
    logic [15:0] d;
    idr_host_i.frame(16'h0000, 15, d);
    idr_host_i.frame(16'h0000, 16, d);
    diag(16'h0008);
    diag(16'h0000);
  endtask
  task automatic t_update();
    for (int k = 0; k < 2; k++) begin
      wr(CMD_ADDR, 8'h08);
      chk(pc[2], k + 1);
      @(posedge clk);
      flash_update_ok <= k[0];
      flash_update_done <= 1'b1;
      overrun <= ~k[0];
      @(posedge clk);
      flash_update_done <= 1'b0;
      overrun <= 1'b0;
      repeat (100) @(posedge clk);
      diag(k ? 16'h0000 : 16'h0006);
    end
    wr(CMD_ADDR, 8'h80);
    chk(pc[3], 1);
  endtask
  // main sequence: reset, then each scenario in turn
  initial begin
    {nrst, self_test_done, accel_fail, gyro1_fail, gyro2_fail, sync_lock_lost} = '0;
    {flash_rd_valid, flash_rd_last, flash_update_done, flash_update_ok} = '0;
    {supply_low, overrun, rate_valid, flash_rd_data, flash_crc_stored} = '0;
    {x_rate, y_rate, z_rate} = '0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_selftest();
    t_sync();
    t_flash();
    t_rate();
    t_supply();
    t_frame();
    t_update();
    summarize();
  end
endmodule
bind idr_diag_spi idr_diag_spi_monitor #(.RECOVER_CYCLES(RECOVER_CYCLES))
  idr_diag_spi_monitor_i (.clk, .nrst, .cs_n, .miso_oe, .self_test_start, .flash_test_start,
  .flash_update_start, .sw_reset_req, .supply_low, .data_halt, .reinit);
`default_nettype wire
